// ---- design/bitbang_consts.vh ----
// constants for the synchronous bit-bang parallel port
// Function
// R01 - output pins change only when a host byte is written to the port
// R02 - output update strobe pulses low after each host byte reaches the pins
// R03 - pins are sampled toward host only as part of a port write
// R04 - next host byte waits until the to-host path has room
// R05 - pins sampled before new byte driven; returned data lags one byte
// R06 - host selects this mode with bit-mode code 0x04
// R07 - host returns to default operation with bit-mode value 0x00
// R08 - first step of each cycle reads current pin state
// R09 - sample strobe goes inactive and sampled byte goes toward host
// R10 - sample strobe active again while output pins take the new byte
// R11 - one cycle data setup, then update strobe active, then inactive
// R12 - external logic treats sample strobe rising edge as capture moment
// R13 - per-pin direction comes from byte-wide mask in setup command
// R14 - direction holds until a new setup command supplies a mask
// R15 - all-input port still runs cycles and returns samples
// R16 - mask bit one makes an output, zero an undriven input
`ifndef BITBANG_CONSTS_VH
`define BITBANG_CONSTS_VH
`define MODE_SYNC_BITBANG 8'h04
`define MODE_RESET        8'h00
`define PIN_RESET         8'h00
`define DIR_RESET         8'h00
`define STROBE_TICKS      2'h2
`define DATA_RESET        8'h00
`define UPDATE_STROBE_RESET 1'h1
`define SAMPLE_STROBE_RESET 1'h0
`endif

// ---- design/byte_buffer.v ----
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ns
module byte_buffer (
    // clock and reset
    input  wire       mclk,
    input  wire       rst_b,
    // fill side
    input  wire [7:0] in_data,
    input  wire       in_valid,
    output wire       in_ready,
    // drain side
    output wire [7:0] out_data,
    output wire       out_valid,
    input  wire       out_ready
);
    reg [7:0] slot_r [0:1];
    reg       wr_ptr_r;
    reg       rd_ptr_r;
    reg [1:0] count_r;
    wire      push;
    wire      pop;

    assign in_ready  = (count_r != 2'd2);
    assign out_valid = (count_r != 2'd0);
    assign out_data  = slot_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge mclk) begin
        if (push) begin
            slot_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ---- design/sync_bitbang_parallel_port.v ----
// synchronous bit-bang parallel port engine
`timescale 1ns/1ns
`include "bitbang_consts.vh"
module sync_bitbang_parallel_port (
    // clock and reset
    input  wire       mclk,
    input  wire       rst_b,
    // mode setup command
    input  wire       setup_valid,
    input  wire [7:0] setup_mode,
    input  wire [7:0] setup_mask,
    // from_host_fifo byte stream
    input  wire [7:0] from_host_fifo_data,
    input  wire       from_host_fifo_valid,
    output wire       from_host_fifo_ready,
    // to_host_fifo byte stream
    output wire [7:0] to_host_fifo_data,
    output wire       to_host_fifo_valid,
    input  wire       to_host_fifo_ready,
    // parallel pins
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out,
    output reg  [7:0] pin_oe_n,
    // strobes
    output reg        output_update_strobe_n,
    output reg        input_sample_strobe_n,
    // status
    output wire       mode_active
);
    localparam [5:0] S_IDLE   = 6'b00_0001;
    localparam [5:0] S_READ   = 6'b00_0010;
    localparam [5:0] S_SEND   = 6'b00_0100;
    localparam [5:0] S_DRIVE  = 6'b00_1000;
    localparam [5:0] S_SETUP  = 6'b01_0000;
    localparam [5:0] S_STROBE = 6'b10_0000;

    // sequencer, setup and strobe timing
    reg  [5:0] state_r;
    reg  [5:0] state_nxt;
    reg  [7:0] mode_r;
    reg  [7:0] mode_nxt;
    reg  [7:0] dir_r;
    reg  [7:0] dir_nxt;
    reg  [1:0] tick_r;
    reg  [1:0] tick_nxt;
    // pin and byte path
    reg  [7:0] pin_meta_r;
    reg  [7:0] pin_sync_r;
    reg  [7:0] sample_r;
    reg  [7:0] sample_nxt;
    reg  [7:0] hold_r;
    reg  [7:0] hold_nxt;
    reg  [7:0] pin_out_nxt;
    reg        update_strobe_n_nxt;
    reg        sample_strobe_n_nxt;
    wire [7:0] drive_en;
    // handshakes
    wire       buf_in_ready;
    wire       push;
    wire       take;
    wire       setup_take;
    wire       in_idle;
    wire       tick_done;
    genvar     g;

    assign in_idle     = (state_r == S_IDLE);
    assign mode_active = (mode_r == `MODE_SYNC_BITBANG);
    // a byte is only taken when the buffer can hold its sample
    assign take        = in_idle & mode_active
                       & from_host_fifo_valid & buf_in_ready; // R04
    assign from_host_fifo_ready = take;

    // setup only between cycles, so a running cycle keeps its mask
    assign setup_take  = setup_valid & in_idle & ~take; // R14

    assign push        = (state_r == S_SEND);
    assign tick_done   = (tick_r == 2'd0);

    // two-flop synchroniser on the asynchronous pin levels
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_r <= `DATA_RESET;
            pin_sync_r <= `DATA_RESET;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // cycle sequencer: read, send, drive, setup, strobe
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:   if (take) state_nxt = S_READ;
            S_READ:   state_nxt = S_SEND;
            S_SEND:   state_nxt = S_DRIVE;
            S_DRIVE:  state_nxt = S_SETUP;
            S_SETUP:  state_nxt = S_STROBE;
            S_STROBE: if (tick_done) state_nxt = S_IDLE;
            default:  state_nxt = S_IDLE;
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // mode and direction mask move only on an accepted setup
    always @* begin
        mode_nxt = mode_r;
        dir_nxt  = dir_r;
        if (setup_take) begin
            mode_nxt = setup_mode; // R13
            dir_nxt  = setup_mask; // R13 R14
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= `MODE_RESET;
            dir_r  <= `DIR_RESET;
        end else begin
            mode_r <= mode_nxt;
            dir_r  <= dir_nxt;
        end
    end

    // host byte is held while the old pin state is captured first
    always @* begin
        hold_nxt   = hold_r;
        sample_nxt = sample_r;
        if (take) begin
            hold_nxt = from_host_fifo_data;
        end
        if (state_r == S_READ) begin
            sample_nxt = pin_sync_r; // R03 R05 R08
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r   <= `DATA_RESET;
            sample_r <= `DATA_RESET;
        end else begin
            hold_r   <= hold_nxt;
            sample_r <= sample_nxt;
        end
    end

    // strobes and pins follow the sequencer one edge behind
    always @* begin
        pin_out_nxt         = pin_out;
        update_strobe_n_nxt = output_update_strobe_n;
        sample_strobe_n_nxt = input_sample_strobe_n;
        tick_nxt            = tick_r;
        case (state_r)
            S_SEND: begin
                sample_strobe_n_nxt = 1'b1; // R09
            end
            S_DRIVE: begin
                sample_strobe_n_nxt = 1'b0;   // R10
                pin_out_nxt         = hold_r; // R01 R10 R15
            end
            S_SETUP: begin
                // pins have settled for one cycle by now
                update_strobe_n_nxt = 1'b0; // R02 R11
                tick_nxt            = `STROBE_TICKS - 2'd1;
            end
            S_STROBE: begin
                if (tick_done) begin
                    update_strobe_n_nxt = 1'b1; // R11
                end else begin
                    tick_nxt = tick_r - 2'd1;
                end
            end
            default: begin
                tick_nxt = tick_r;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out                <= `PIN_RESET;
            output_update_strobe_n <= `UPDATE_STROBE_RESET;
            input_sample_strobe_n  <= `SAMPLE_STROBE_RESET;
            tick_r                 <= 2'd0;
        end else begin
            pin_out                <= pin_out_nxt;
            output_update_strobe_n <= update_strobe_n_nxt;
            input_sample_strobe_n  <= sample_strobe_n_nxt;
            tick_r                 <= tick_nxt;
        end
    end

    // one enable per pin; a zero mask bit leaves the pin undriven
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin_dir
            assign drive_en[g] = dir_r[g] & mode_active; // R16
        end
    endgenerate

    // everything undriven while the port is out of this mode
    always @* begin
        pin_oe_n = ~drive_en; // R15 R16
    end

    byte_buffer u_to_host_buf (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_data   (sample_r),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .out_data  (to_host_fifo_data),
        .out_valid (to_host_fifo_valid),
        .out_ready (to_host_fifo_ready)
    );
endmodule

// ---- test/port_sva.sv ----
// assertions on the bit-bang port
`timescale 1ns/1ns
module port_sva (
    input wire       mclk,
    input wire       rst_b,
    input wire       setup_valid,
    input wire       from_host_fifo_valid,
    input wire       from_host_fifo_ready,
    input wire       to_host_fifo_valid,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe_n,
    input wire       output_update_strobe_n,
    input wire       input_sample_strobe_n,
    input wire       mode_active
);
    wire tk = from_host_fifo_valid && from_host_fifo_ready;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_pins_hold: assert property (
        !$stable(pin_out) |-> $past(tk, 4)) else $error("pin move");
    chk_upd_pulse: assert property (
        tk |-> ##5 !output_update_strobe_n [*2] ##1 output_update_strobe_n)
        else $error("update strobe");
    chk_smp_pulse: assert property (
        tk |-> ##3 input_sample_strobe_n ##1 !input_sample_strobe_n)
        else $error("sample strobe");
    chk_smp_cause: assert property (
        $rose(input_sample_strobe_n) |-> $past(tk, 3)) else $error("sample");
    chk_one_byte: assert property (
        tk |=> !from_host_fifo_ready [*6]) else $error("busy take");
    chk_ans_valid: assert property (
        tk |-> ##3 to_host_fifo_valid) else $error("no answer");
    chk_mode_off: assert property (
        !mode_active |-> pin_oe_n == 8'hFF) else $error("driven idle");
    chk_dir_hold: assert property (
        !$stable(pin_oe_n) |-> $past(setup_valid) || $past(setup_valid, 2))
        else $error("dir moved");
endmodule
bind sync_bitbang_parallel_port port_sva u_sva (
    .mclk                   (mclk),
    .rst_b                  (rst_b),
    .setup_valid            (setup_valid),
    .from_host_fifo_valid   (from_host_fifo_valid),
    .from_host_fifo_ready   (from_host_fifo_ready),
    .to_host_fifo_valid     (to_host_fifo_valid),
    .pin_out                (pin_out),
    .pin_oe_n               (pin_oe_n),
    .output_update_strobe_n (output_update_strobe_n),
    .input_sample_strobe_n  (input_sample_strobe_n),
    .mode_active            (mode_active)
);

// ---- test/pin_partner.sv ----
// external logic on the pins: drives every pin the port leaves undriven
`timescale 1ns/1ns
module pin_partner (
    input  wire [7:0] pin_out,
    input  wire [7:0] pin_oe_n,
    input  wire [7:0] ext,
    input  wire       input_sample_strobe_n,
    output wire [7:0] pin_in,
    output reg  [7:0] captured
);
    assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
    // rising sample strobe marks the byte just sent to the host
    always @(posedge input_sample_strobe_n) captured <= pin_in;
endmodule

// ---- test/tb.sv ----
// testbench for the synchronous bit-bang port
`timescale 1ns/1ns
module tb;
    reg        mclk, rst_b, sv, fv, tr, ok;
    reg  [7:0] sm, sk, fd, ext;
    wire       fr, tv, wn, rn, ma;
    wire [7:0] td, pi, po, oe, cap;
    integer    n_errors, checks, i;
    reg  [7:0] q[$];
    sync_bitbang_parallel_port DUT (.mclk(mclk), .rst_b(rst_b),
        .setup_valid(sv), .setup_mode(sm), .setup_mask(sk),
        .from_host_fifo_data(fd), .from_host_fifo_valid(fv),
        .from_host_fifo_ready(fr), .to_host_fifo_data(td),
        .to_host_fifo_valid(tv), .to_host_fifo_ready(tr), .pin_in(pi),
        .pin_out(po), .pin_oe_n(oe), .output_update_strobe_n(wn),
        .input_sample_strobe_n(rn), .mode_active(ma));
    pin_partner u_pins (.pin_out(po), .pin_oe_n(oe), .ext(ext),
        .input_sample_strobe_n(rn), .pin_in(pi), .captured(cap));
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    always @(negedge mclk) if (tv && tr) q.push_back(td);
    task cmp(input string nm, input [7:0] e, input [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("Error %s exp %h got %h", nm, e, g);
        end
    endtask
    task setup(input [7:0] m, input [7:0] k);
        @(posedge mclk) begin sv <= 1; sm <= m; sk <= k; end
        @(posedge mclk) sv <= 0;
        repeat (3) @(posedge mclk);
        q.delete();
    endtask
    task send(input [7:0] d);
        @(posedge mclk) begin fv <= 1; fd <= d; end
        ok = 0;
        for (i = 0; i < 20 && !ok; i++) begin
            @(negedge mclk) ok = fr;
            if (!ok) @(posedge mclk);
        end
        @(posedge mclk) fv <= 0;
    endtask
    task t_reset;
        repeat (2) @(posedge mclk);
        cmp("rst_pins", 8'h00, po);
        cmp("rst_oe", 8'hFF, oe);
        cmp("rst_ans", 8'h00, {7'h00, tv});
        cmp("rst_upd", 8'h01, {7'h00, wn});
        cmp("rst_mode", 8'h00, {7'h00, ma});
    endtask
    task t_lag;
        setup(8'h04, 8'hFF);
        cmp("active", 8'h01, {7'h00, ma});
        send(8'hFF); send(8'h55); send(8'hAA); send(8'hAA);
        repeat (12) @(posedge mclk);
        cmp("lag_n", 8'h04, q.size());
        cmp("capt", 8'hAA, cap);
        cmp("back0", 8'h00, q[0]); cmp("back1", 8'hFF, q[1]);
        cmp("back2", 8'h55, q[2]); cmp("back3", 8'hAA, q[3]);
        cmp("pins", 8'hAA, po);
    endtask
    task t_stall;
        tr <= 0;
        q.delete();
        send(8'h11); send(8'h22); send(8'h33);
        cmp("third", 8'h00, {7'h00, ok});
        tr <= 1;
        repeat (12) @(posedge mclk);
        cmp("st0", 8'hAA, q[0]); cmp("st1", 8'h11, q[1]);
        cmp("count", 8'h02, q.size());
    endtask
    task t_mask;
        ext <= 8'hA5;
        setup(8'h04, 8'h0F);
        cmp("oe", 8'hF0, oe);
        send(8'h3C); send(8'h3C);
        repeat (12) @(posedge mclk);
        cmp("m0", 8'hA2, q[0]); cmp("m1", 8'hAC, q[1]);
        cmp("capt_m", 8'hAC, cap);
        cmp("oe2", 8'hF0, oe);
    endtask
    task t_inputs;
        setup(8'h04, 8'h00);
        send(8'h99);
        repeat (12) @(posedge mclk);
        cmp("in0", 8'hA5, q[0]); cmp("pin", 8'hA5, pi);
    endtask
    task t_mode0;
        setup(8'h00, 8'hFF);
        send(8'h77);
        cmp("off", 8'h00, {7'h00, ok}); cmp("oe0", 8'hFF, oe);
        cmp("inactive", 8'h00, {7'h00, ma});
    endtask
    task final_report;
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        final_report;
    end
    initial begin
        n_errors = 0; checks = 0; rst_b = 0; sv = 0; fv = 0; tr = 1;
        sm = 0; sk = 0; fd = 0; ext = 0;
        repeat (6) @(posedge mclk);
        rst_b <= 1;
        t_reset; t_lag; t_stall; t_mask; t_inputs; t_mode0;
        final_report;
    end
endmodule
